/* File: src/uisp_pkg.sv */
// constants shared by the interrupt identification block
package uisp_pkg;
    // register bus geometry
    localparam int UISP_AW = 4;
    localparam int UISP_DW = 8;
    // register offsets
    localparam logic [3:0] UISP_OFF_IDENT = 4'h0;
    localparam logic [3:0] UISP_OFF_CTRL = 4'h1;
    localparam logic [3:0] UISP_OFF_EVSTAT = 4'h2;
    localparam logic [3:0] UISP_OFF_EVMASK = 4'h3;
    // control register fields
    localparam int UISP_CTRL_FIFO_BIT = 0;
    localparam int UISP_CTRL_ENH_BIT = 1;
    localparam logic [1:0] UISP_CTRL_RST = 2'h0;
    // identification register fields
    localparam int UISP_ID_NONE_BIT = 0;
    localparam logic [1:0] UISP_ID_FIFO_ON = 2'h3;
    localparam logic [1:0] UISP_ID_FIFO_OFF = 2'h0;
    localparam logic [7:0] UISP_ID_RST = 8'h01;
    // number of pending sources
    localparam int UISP_NSRC = 7;
    // source indexes in priority order, highest first
    localparam logic [2:0] UISP_SRC_LINE = 3'h0;
    localparam logic [2:0] UISP_SRC_RXDATA = 3'h1;
    localparam logic [2:0] UISP_SRC_RXTO = 3'h2;
    localparam logic [2:0] UISP_SRC_TXEMPTY = 3'h3;
    localparam logic [2:0] UISP_SRC_MODEM = 3'h4;
    localparam logic [2:0] UISP_SRC_XOFF = 3'h5;
    localparam logic [2:0] UISP_SRC_FLOWCHG = 3'h6;
    // identification codes on bits five down to zero
    localparam logic [5:0] UISP_CODE_LINE = 6'h06;
    localparam logic [5:0] UISP_CODE_RXDATA = 6'h04;
    localparam logic [5:0] UISP_CODE_RXTO = 6'h0C;
    localparam logic [5:0] UISP_CODE_TXEMPTY = 6'h02;
    localparam logic [5:0] UISP_CODE_MODEM = 6'h00;
    localparam logic [5:0] UISP_CODE_XOFF = 6'h10;
    localparam logic [5:0] UISP_CODE_FLOWCHG = 6'h20;
    localparam logic [5:0] UISP_CODE_NONE = 6'h01;
    // reset values of pending and event state
    localparam logic [6:0] UISP_PEND_RST = 7'h00;
    localparam logic [6:0] UISP_EV_RST = 7'h00;
endpackage : uisp_pkg

/* File: src/uisp_rank.sv */
// priority ranking of pending interrupt sources
`timescale 1ns/1ps
module uisp_rank
    import uisp_pkg::*;
(
    // pending sources, index 0 highest
    input wire logic [6:0] pend_in,
    // enhanced features allow the two lowest levels
    input wire logic enh_in,
    // selected source
    output logic found_out,
    output logic [2:0] sel_out
);
    logic [6:0] eligible;

    // lowest two levels only take part with enhanced features on
    always_comb begin
        eligible = pend_in;
        if (!enh_in) begin
            eligible[UISP_SRC_XOFF] = 1'b0;
            eligible[UISP_SRC_FLOWCHG] = 1'b0;
        end
    end

    // first set bit wins; scan from the lowest so the highest overrides
    always_comb begin
        found_out = 1'b0;
        sel_out = 3'h0;
        for (int i = UISP_NSRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                found_out = 1'b1;
                sel_out = 3'(i);
            end
        end
    end
endmodule : uisp_rank

/* File: src/uisp_top.sv */
// interrupt identification and priority logic for one uart channel
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module uisp_top
    import uisp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register bus
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // interrupt source events, one-cycle pulses
    input wire logic line_error_in,
    input wire logic rx_data_in,
    input wire logic rx_timeout_in,
    input wire logic tx_empty_in,
    input wire logic modem_change_in,
    input wire logic xoff_detect_in,
    input wire logic xon_detect_in,
    input wire logic flow_change_in,
    // service strobes from the owning source logic, one-cycle pulses
    input wire logic rx_drained_in,
    input wire logic tx_loaded_in,
    // status towards the host
    output logic irq_out,
    output logic pending_out,
    output logic [2:0] source_out
);
    // control and event registers
    logic fifo_en_q;
    logic enh_en_q;
    logic [6:0] ev_stat_q;
    logic [6:0] ev_mask_q;
    // pending sources and the latched report
    logic [6:0] pend_q;
    logic [6:0] pend_set;
    logic [6:0] pend_clr;
    logic cur_valid_q;
    logic [2:0] cur_q;
    logic [7:0] rdata_q;
    logic irq_q;
    // ranking result
    logic rank_found;
    logic [2:0] rank_sel;
    // bus decode
    logic rd_ident;
    logic wr_ctrl;
    logic wr_evstat;
    logic wr_evmask;
    logic serviced;
    // report seen by a read: the latched one, else the current winner
    logic rep_valid;
    logic [2:0] rep_src;

    // code on bits five down to zero for one source
    function automatic logic [5:0] uisp_code(input logic [2:0] src);
        logic [5:0] c;
        c = UISP_CODE_NONE;
        unique case (src)
            UISP_SRC_LINE: c = UISP_CODE_LINE;
            UISP_SRC_RXDATA: c = UISP_CODE_RXDATA;
            UISP_SRC_RXTO: c = UISP_CODE_RXTO;
            UISP_SRC_TXEMPTY: c = UISP_CODE_TXEMPTY;
            UISP_SRC_MODEM: c = UISP_CODE_MODEM;
            UISP_SRC_XOFF: c = UISP_CODE_XOFF;
            UISP_SRC_FLOWCHG: c = UISP_CODE_FLOWCHG;
            default: c = UISP_CODE_NONE;
        endcase
        return c;
    endfunction : uisp_code

    // one-hot of a source index
    function automatic logic [6:0] uisp_onehot(input logic [2:0] src);
        logic [6:0] v;
        v = 7'h00;
        if (src < 3'(UISP_NSRC)) begin
            v[src] = 1'b1;
        end
        return v;
    endfunction : uisp_onehot

    // full identification byte for the report seen by a read
    function automatic logic [7:0] uisp_ident(input logic valid, input logic [2:0] src,
                                              input logic fifo, input logic enh);
        logic [7:0] v;
        v = UISP_ID_RST;
        if (valid) begin
            v[5:0] = uisp_code(src);
        end
        // upper priority bits masked off without enhanced features
        if (!enh) begin
            v[5:4] = 2'h0;
        end
        v[7:6] = fifo ? UISP_ID_FIFO_ON : UISP_ID_FIFO_OFF;
        return v;
    endfunction : uisp_ident

    // register strobes
    assign rd_ident = rd_in && (addr_in == UISP_OFF_IDENT);
    assign wr_ctrl = wr_in && (addr_in == UISP_OFF_CTRL);
    assign wr_evstat = wr_in && (addr_in == UISP_OFF_EVSTAT);
    assign wr_evmask = wr_in && (addr_in == UISP_OFF_EVMASK);

    // a read with nothing latched takes the ranking winner directly, so a read
    // straight after another never misses a source that is still pending
    assign rep_valid = cur_valid_q || rank_found;
    assign rep_src = cur_valid_q ? cur_q : rank_sel;

    // a report is serviced by the host read while one stands
    assign serviced = rd_ident && rep_valid;

    // ranking of what is still pending
    uisp_rank u_rank (
        .pend_in(pend_q),
        .enh_in(enh_en_q),
        .found_out(rank_found),
        .sel_out(rank_sel)
    );

    // event pulses gathered into source positions
    always_comb begin
        pend_set = 7'h00;
        pend_set[UISP_SRC_LINE] = line_error_in;
        pend_set[UISP_SRC_RXDATA] = rx_data_in;
        pend_set[UISP_SRC_RXTO] = rx_timeout_in;
        pend_set[UISP_SRC_TXEMPTY] = tx_empty_in;
        pend_set[UISP_SRC_MODEM] = modem_change_in;
        pend_set[UISP_SRC_XOFF] = xoff_detect_in;
        pend_set[UISP_SRC_FLOWCHG] = flow_change_in;
    end

    // clears: the read clears only the reported source, xoff waits for xon
    always_comb begin
        pend_clr = 7'h00;
        if (serviced && rep_src != UISP_SRC_XOFF) begin
            pend_clr = uisp_onehot(rep_src);
        end
        pend_clr[UISP_SRC_XOFF] = xon_detect_in;
        // the data path can service its own sources before any read
        if (rx_drained_in) begin
            pend_clr[UISP_SRC_RXDATA] = 1'b1;
            pend_clr[UISP_SRC_RXTO] = 1'b1;
        end
        if (tx_loaded_in) begin
            pend_clr[UISP_SRC_TXEMPTY] = 1'b1;
        end
    end

    // pending flags; a new event in the clearing cycle survives
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pend_q <= UISP_PEND_RST;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | pend_set;
        end
    end

    // latched report: held while unserviced so higher sources cannot displace it
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            cur_valid_q <= 1'b0;
            cur_q <= 3'h0;
        end else if (cur_valid_q) begin
            // dropped when read, when its source went away by other means, or when enhanced off hides xoff or flow change
            if (serviced || !pend_q[cur_q]) begin
                cur_valid_q <= 1'b0;
            end else if (!enh_en_q && cur_q >= UISP_SRC_XOFF) begin
                cur_valid_q <= 1'b0;
            end
        end else if (rank_found && !serviced) begin
            // a winner taken by a read in this cycle is already serviced
            cur_valid_q <= 1'b1;
            cur_q <= rank_sel;
        end
    end

    // control register: fifo mode and enhanced features
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            fifo_en_q <= UISP_CTRL_RST[UISP_CTRL_FIFO_BIT];
            enh_en_q <= UISP_CTRL_RST[UISP_CTRL_ENH_BIT];
        end else if (wr_ctrl) begin
            fifo_en_q <= wdata_in[UISP_CTRL_FIFO_BIT];
            enh_en_q <= wdata_in[UISP_CTRL_ENH_BIT];
        end
    end

    // sticky event status, write one to clear; set wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ev_stat_q <= UISP_EV_RST;
        end else begin
            if (wr_evstat) begin
                ev_stat_q <= (ev_stat_q & ~wdata_in[6:0]) | pend_set;
            end else begin
                ev_stat_q <= ev_stat_q | pend_set;
            end
        end
    end

    // event mask, one enables the bit onto the interrupt line
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ev_mask_q <= UISP_EV_RST;
        end else if (wr_evmask) begin
            ev_mask_q <= wdata_in[6:0];
        end
    end

    // interrupt level, registered so the pin comes from a flip-flop
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ev_stat_q & ev_mask_q);
        end
    end

    // read data, valid only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                UISP_OFF_IDENT: rdata_q <= uisp_ident(rep_valid, rep_src, fifo_en_q, enh_en_q);
                UISP_OFF_CTRL: rdata_q <= {6'h00, enh_en_q, fifo_en_q};
                UISP_OFF_EVSTAT: rdata_q <= {1'b0, ev_stat_q};
                UISP_OFF_EVMASK: rdata_q <= {1'b0, ev_mask_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // report status registered from the latched report, one cycle behind it
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pending_out <= 1'b0;
            source_out <= 3'h0;
        end else begin
            pending_out <= cur_valid_q;
            source_out <= cur_q;
        end
    end

    assign rdata_out = rdata_q;
    assign irq_out = irq_q;
endmodule : uisp_top

/* File: sim/uisp_checker.sv */
// concurrent checks on the identification block ports
`timescale 1ns/1ps
module uisp_checker
    import uisp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // register bus and status
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out,
    input wire logic pending_out,
    input wire logic [2:0] source_out
);
    logic [1:0] ctrl_q;
    logic [6:0] mask_q;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // shadows of ctrl and mask, followed from bus writes
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ctrl_q <= 2'h0;
            mask_q <= 7'h00;
        end else if (wr_in && addr_in == 4'h1) begin
            ctrl_q <= wdata_in[1:0];
        end else if (wr_in && addr_in == 4'h3) begin
            mask_q <= wdata_in[6:0];
        end
    end
    a_read_once: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its slot");
    a_ident_code: assert property (rd_in && addr_in == 4'h0 |=> rdata_out[5:0] inside
        {6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
        else $error("identification code not legal");
    a_none_bit: assert property (rd_in && addr_in == 4'h0 ##1 rdata_out[0]
        |-> rdata_out[5:1] == 5'h00)
        else $error("idle flag with a source code");
    a_fifo_bits: assert property (rd_in && addr_in == 4'h0
        |=> rdata_out[7:6] == {2{ctrl_q[0]}})
        else $error("fifo bits wrong");
    a_enh_gate: assert property (rd_in && addr_in == 4'h0 && !ctrl_q[1]
        |=> rdata_out[5:4] == 2'h0)
        else $error("high level bits with enhanced off");
    a_unmapped_zero: assert property (rd_in && addr_in > 4'h3 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(rstn_in)
        |-> !irq_out && !pending_out && rdata_out == 8'h00)
        else $error("outputs busy after reset");
    a_irq_masked: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00
        |-> !irq_out)
        else $error("interrupt while all masked");
    a_source_range: assert property (pending_out |-> source_out <= 3'h6)
        else $error("source index out of range");
endmodule : uisp_checker

/* File: sim/uisp_host.sv */
// host bus master model for the register port
`timescale 1ns/1ps
module uisp_host (
    // clock and read data
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    // bus requests
    output logic [3:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // idle bus at time zero
    initial begin
        addr_out = 4'h0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one-cycle write strobe
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d; // stale data must never look valid
    endtask : wr_reg
    // data stands only in the cycle after the strobe
    task rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        v = rdata_in;
    endtask : rd_reg
    // two reads with no gap; each answer is taken in the cycle after its strobe
    task rd_two(input logic [3:0] a, output logic [7:0] v0, output logic [7:0] v1);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        #1;
        v0 = rdata_in;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        v1 = rdata_in;
    endtask : rd_two
endmodule : uisp_host

/* File: sim/uisp_top_bench.sv */
// self-checking bench for the interrupt identification block
`timescale 1ns/1ps
module uisp_top_bench;
    import uisp_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] addr_in;
    logic [7:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [7:0] rdata_out;
    logic irq_out;
    logic pending_out;
    logic [2:0] source_out;
    logic [7:0] rv0;
    logic [7:0] rv1;
    logic [9:0] ev = 10'h000; // sources by index, then xon, drained, loaded
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    logic [5:0] codes [7] = '{6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20};
    logic [7:0] prio [4] = '{8'hC6, 8'hC2, 8'hE0, 8'hC1};
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    uisp_host host_u (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
        .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
    uisp_top dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .line_error_in(ev[0]), .rx_data_in(ev[1]), .rx_timeout_in(ev[2]),
        .tx_empty_in(ev[3]), .modem_change_in(ev[4]), .xoff_detect_in(ev[5]),
        .flow_change_in(ev[6]), .xon_detect_in(ev[7]), .rx_drained_in(ev[8]),
        .tx_loaded_in(ev[9]), .irq_out(irq_out), .pending_out(pending_out),
        .source_out(source_out));
    task finish_test();
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        host_u.rd_reg(a, v);
        check("read", v, exp);
    endtask : rd_chk
    // one-cycle event pulses, with the two edges the report needs to form
    task pulse(input logic [9:0] m);
        @(posedge clk_in);
        ev <= m;
        @(posedge clk_in);
        ev <= 10'h000;
    endtask : pulse
    // hang guard, well above the roughly 140 cycles the run takes
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd_chk(4'h0, 8'h01);
        rd_chk(4'h9, 8'h00);
        host_u.wr_reg(4'h1, 8'h02);
        host_u.wr_reg(4'h3, 8'h7F);
        rd_chk(4'h3, 8'h7F);
        // each source alone: code, clear on read (xoff only by xon), irq until status cleared
        for (int i = 0; i < 7; i++) begin
            pulse(10'h001 << i);
            rd_chk(4'h0, {2'h0, codes[i]});
            check("irq", {7'h00, irq_out}, 8'h01);
            check("report", {4'h0, pending_out, source_out}, {4'h0, 1'b1, 3'(i)});
            rd_chk(4'h0, (i == 5) ? 8'h10 : 8'h01);
            if (i == 5) begin
                pulse(10'h080);
                rd_chk(4'h0, 8'h01);
            end
            host_u.wr_reg(4'h2, 8'h01 << i);
            repeat (2) @(posedge clk_in);
            #1;
            check("irq", {7'h00, irq_out}, 8'h00);
        end
        // fifo on: three levels at once, reported highest first
        host_u.wr_reg(4'h1, 8'h03);
        pulse(10'h049);
        foreach (prio[k]) rd_chk(4'h0, prio[k]);
        pulse(10'h006);
        rd_chk(4'h0, 8'hC4);
        rd_chk(4'h0, 8'hCC);
        // back-to-back reads: the second one already shows the next source
        pulse(10'h009);
        host_u.rd_two(4'h0, rv0, rv1);
        check("ident", rv0, 8'hC6);
        check("ident", rv1, 8'hC2);
        // a latched report is not displaced by a higher arrival
        pulse(10'h008);
        pulse(10'h001);
        rd_chk(4'h0, 8'hC2);
        rd_chk(4'h0, 8'hC6);
        // service strobes withdraw the report
        pulse(10'h002);
        pulse(10'h100);
        rd_chk(4'h0, 8'hC1);
        pulse(10'h008);
        pulse(10'h200);
        rd_chk(4'h0, 8'hC1);
        // enhanced off hides levels five and six
        host_u.wr_reg(4'h1, 8'h01);
        pulse(10'h060);
        rd_chk(4'h0, 8'hC1);
        pulse(10'h010);
        rd_chk(4'h0, 8'hC0);
        finish_test();
    end
endmodule : uisp_top_bench
bind uisp_top uisp_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .pending_out(pending_out), .source_out(source_out));
